/* rtl/pft_table_access.sv */
// program flash table access sequencer: table read, table write,
// 8-byte block write and 64-byte block erase through one byte latch
// assumes a 16-bit flash array answering a read in the same cycle rd is presented and
// a core that issues one table operation at a time
//
// Behaviour
// R1: flash access works during normal operation
// R2: each table read yields one byte
// R3: write commits a whole 8-byte block
// R4: erase clears a whole 64-byte block
// R5: self-requested bulk erase is refused
// R6: fetch stalls during write or erase
// R7: programming timer ends write and erase
// R8: invalid opcodes execute as no-operation
// R9: 16-bit program words, byte addressed
// R10: all transfers pass the 8-bit latch
// R11: table read loads addressed byte into latch
// R12: table write fills holding register only
// R13: table transfers need no word alignment
// R14: software word-aligns written executable code
// R15: low pointer bits pick holding register
// R16: erase block from pointer bits 21:6
// R17: three byte registers form 22-bit pointer
// R18: start bits cleared by hardware when done
`timescale 1ns/10ps
module pft_table_access
    import pft_pkg::*;
(
    input  wire logic                   CLK_SYS,
    input  wire logic                   RST,
    input  wire pft_table_req_t         TBL_REQ,
    input  wire logic [PFT_BYTE_W-1:0]  LATCH_WDATA,
    input  wire logic                   LATCH_WE,
    input  wire logic [PFT_BYTE_W-1:0]  PTR_WDATA,
    input  wire logic [2:0]             PTR_WE,
    input  wire logic                   WRITE_START,
    input  wire logic                   ERASE_SEL,
    input  wire logic                   BULK_REQ,
    input  wire logic [PFT_WORD_W-1:0]  FETCH_WORD,
    input  wire logic [PFT_WORD_W-1:0]  ARRAY_RDATA,
    output pft_array_req_t              ARRAY_REQ,
    output logic [PFT_BYTE_W-1:0]       TABLE_LATCH,
    output logic [PFT_PTR_W-1:0]        TABLE_POINTER,
    output logic                        READ_BUSY,
    output logic                        WRITE_BUSY,
    output logic                        FETCH_STALL,
    output logic                        BULK_REFUSED,
    output logic                        INSN_NOP,
    output logic                        TBL_DONE
);
    // =========================================================
    // sequencer state
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_PROG,
        ST_ERASE,
        ST_DONE
    } pft_state_t;

    pft_state_t              st_r, st_nxt;
    logic [PFT_PTR_W-1:0]    ptr_r, ptr_nxt;
    logic [PFT_BYTE_W-1:0]   latch_r, latch_nxt;
    logic                    rd_lo_r, rd_lo_nxt;
    pft_ptr_mode_t           post_r, post_nxt;
    logic                    rd_bit_r, rd_bit_nxt;
    logic                    wr_bit_r, wr_bit_nxt;
    logic                    refused_r, refused_nxt;
    logic                    done_r, done_nxt;
    pft_array_req_t          areq_r, areq_nxt;
    logic [PFT_ERASE_W-1:0]  ecnt_r, ecnt_nxt;

    logic                        hold_we;
    logic                        hold_clr;
    logic [PFT_HOLD_N*PFT_BYTE_W-1:0] hold_bytes;
    logic [PFT_HOLD_N-1:0]       hold_dirty;
    logic                        tmr_start;
    logic [PFT_TMR_W-1:0]        tmr_load;
    logic                        tmr_busy;
    logic                        tmr_done;
    logic [PFT_PTR_W-1:0]        ptr_eff;

    // =========================================================
    // helpers
    pft_hold_bank #(.N(PFT_HOLD_N)) u_hold (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .wr_en   (hold_we),
        .wr_sel  (ptr_eff[PFT_HOLD_SEL_W-1:0]),
        .wr_data (latch_r),
        .clr     (hold_clr),
        .bytes_q (hold_bytes),
        .dirty_q (hold_dirty)
    );

    pft_prog_timer u_tmr (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .start   (tmr_start),
        .load    (tmr_load),
        .busy    (tmr_busy),
        .done    (tmr_done)
    );

    // pre-increment affects the access itself; only low 21 bits wrap
    always_comb begin
        ptr_eff = ptr_r;
        if (TBL_REQ.mode == PFT_PTR_PREINC)
            ptr_eff = {ptr_r[PFT_PTR_W-1],
                       ptr_r[PFT_PTR_W-2:0] + 1'b1};
    end

    function automatic logic [PFT_PTR_W-1:0] upd_ptr(
        input logic [PFT_PTR_W-1:0] p,
        input pft_ptr_mode_t        m
    );
        logic [PFT_PTR_W-2:0] lo;
        lo = p[PFT_PTR_W-2:0];
        unique case (m)
            PFT_PTR_POSTINC: lo = lo + 1'b1;
            PFT_PTR_POSTDEC: lo = lo - 1'b1;
            PFT_PTR_KEEP,
            PFT_PTR_PREINC:  lo = lo;
        endcase
        return {p[PFT_PTR_W-1], lo};
    endfunction

    // =========================================================
    // next state
    always_comb begin
        st_nxt      = st_r;
        ptr_nxt     = ptr_r;
        latch_nxt   = latch_r;
        rd_lo_nxt   = rd_lo_r;
        post_nxt    = post_r;
        rd_bit_nxt  = rd_bit_r;
        wr_bit_nxt  = wr_bit_r;
        refused_nxt = 1'b0;
        done_nxt    = 1'b0;
        areq_nxt    = '0;
        ecnt_nxt    = ecnt_r;
        hold_we     = 1'b0;
        hold_clr    = 1'b0;
        tmr_start   = 1'b0;
        tmr_load    = '0;

        // pointer bytes are software visible registers [R17]
        for (int b = 0; b < 3; b++) begin
            if (PTR_WE[b] && st_r == ST_IDLE) begin
                if (b == 2)
                    ptr_nxt[PFT_PTR_W-1:16] =
                        PTR_WDATA[PFT_PTR_W-17:0];
                else
                    ptr_nxt[b*8 +: 8] = PTR_WDATA;
            end
        end
        if (LATCH_WE && st_r == ST_IDLE)
            latch_nxt = LATCH_WDATA;

        unique case (st_r)
            ST_IDLE: begin
                if (BULK_REQ) begin
                    refused_nxt = 1'b1;                           // [R5]
                end else if (TBL_REQ.read_op) begin
                    // any byte address, odd or even [R13]
                    areq_nxt.rd    = 1'b1;                        // [R9]
                    areq_nxt.waddr = ptr_eff[PFT_PTR_W-1:1];
                    rd_lo_nxt      = ~ptr_eff[0];
                    post_nxt       = TBL_REQ.mode;
                    ptr_nxt        = ptr_eff;
                    rd_bit_nxt     = 1'b1;
                    st_nxt         = ST_RD_WAIT;
                end else if (TBL_REQ.write_op) begin
                    hold_we  = 1'b1;                          // [R12] [R15]
                    ptr_nxt  = upd_ptr(ptr_eff, TBL_REQ.mode);
                    done_nxt = 1'b1;
                end else if (WRITE_START && ERASE_SEL) begin
                    wr_bit_nxt = 1'b1;                            // [R1]
                    ecnt_nxt   = '0;
                    tmr_start  = 1'b1;                            // [R7]
                    tmr_load   = PFT_TMR_W'(PFT_ERASE_CYC);
                    st_nxt     = ST_ERASE;
                end else if (WRITE_START) begin
                    wr_bit_nxt = 1'b1;
                    ecnt_nxt   = '0;
                    tmr_start  = 1'b1;                            // [R7]
                    tmr_load   = PFT_TMR_W'(PFT_WRITE_CYC);
                    st_nxt     = ST_PROG;
                end
            end
            ST_RD_WAIT: begin
                // one byte of the returned word into the latch [R2] [R11]
                latch_nxt  = rd_lo_r ? ARRAY_RDATA[7:0]
                                     : ARRAY_RDATA[15:8];         // [R10]
                ptr_nxt    = upd_ptr(ptr_r, post_r);
                rd_bit_nxt = 1'b0;                                // [R18]
                done_nxt   = 1'b1;
                st_nxt     = ST_IDLE;
            end
            ST_PROG: begin
                // one word per cycle, pointer bits 2:0 ignored [R3] [R15]
                if (ecnt_r < PFT_ERASE_W'(PFT_HOLD_N / 2)) begin
                    areq_nxt.prog  = 1'b1;
                    areq_nxt.waddr = {ptr_r[PFT_PTR_W-1:PFT_HOLD_SEL_W],
                                      ecnt_r[1:0]};
                    areq_nxt.wdata = {hold_bytes[ecnt_r[1:0]*16 + 8 +: 8],
                                      hold_bytes[ecnt_r[1:0]*16 +: 8]};
                    areq_nxt.wbe   = {hold_dirty[ecnt_r[1:0]*2 + 1],
                                      hold_dirty[ecnt_r[1:0]*2]};
                    ecnt_nxt       = ecnt_r + 1'b1;
                end
                if (tmr_done) begin
                    hold_clr = 1'b1;                              // [R7]
                    st_nxt   = ST_DONE;
                end
            end
            ST_ERASE: begin
                // 32 words of the block from bits 21:6 [R4] [R16]
                // counter runs one past the last word so pulses stop
                if (ecnt_r < PFT_ERASE_W'(PFT_ERASE_N / 2)) begin
                    areq_nxt.erase = 1'b1;
                    areq_nxt.waddr = {ptr_r[PFT_PTR_W-1:PFT_ERASE_LSB],
                                      ecnt_r[PFT_ERASE_LSB-2:0]};
                    ecnt_nxt       = ecnt_r + 1'b1;
                end
                if (tmr_done)
                    st_nxt = ST_DONE;                             // [R7]
            end
            ST_DONE: begin
                wr_bit_nxt = 1'b0;                                // [R18]
                done_nxt   = 1'b1;
                st_nxt     = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st_r      <= ST_IDLE;
            ptr_r     <= '0;
            latch_r   <= '0;
            rd_lo_r   <= 1'b0;
            post_r    <= PFT_PTR_KEEP;
            rd_bit_r  <= 1'b0;
            wr_bit_r  <= 1'b0;
            refused_r <= 1'b0;
            done_r    <= 1'b0;
            areq_r    <= '0;
            ecnt_r    <= '0;
        end else begin
            st_r      <= st_nxt;
            ptr_r     <= ptr_nxt;
            latch_r   <= latch_nxt;
            rd_lo_r   <= rd_lo_nxt;
            post_r    <= post_nxt;
            rd_bit_r  <= rd_bit_nxt;
            wr_bit_r  <= wr_bit_nxt;
            refused_r <= refused_nxt;
            done_r    <= done_nxt;
            areq_r    <= areq_nxt;
            ecnt_r    <= ecnt_nxt;
        end
    end

    // =========================================================
    // outputs
    assign ARRAY_REQ     = areq_r;
    assign TABLE_LATCH   = latch_r;
    assign TABLE_POINTER = ptr_r;
    assign READ_BUSY     = rd_bit_r;
    assign WRITE_BUSY    = wr_bit_r;
    assign BULK_REFUSED  = refused_r;
    assign TBL_DONE      = done_r;
    // array is unreachable for code while programming [R6]
    assign FETCH_STALL   = wr_bit_r || tmr_busy;
    // erased or blank words decode as no-operation [R8]
    assign INSN_NOP      = (FETCH_WORD == 16'hffff);

    // =========================================================
    // checks
    stall_during_prog_a: assert property (                // [R6]
        @(posedge CLK_SYS) disable iff (RST)
        (st_r == ST_PROG || st_r == ST_ERASE) |-> FETCH_STALL)
        else $error("fetch not stalled while programming");
    bulk_never_erase_a: assert property (                 // [R5]
        @(posedge CLK_SYS) disable iff (RST)
        BULK_REFUSED |-> !ARRAY_REQ.erase && !ARRAY_REQ.bulk)
        else $error("bulk erase reached the array");
    read_clears_bit_a: assert property (                  // [R18]
        @(posedge CLK_SYS) disable iff (RST)
        $rose(READ_BUSY) |=> !READ_BUSY && TBL_DONE)
        else $error("read start bit not cleared after one cycle");
    read_addr_word_a: assert property (                   // [R11]
        @(posedge CLK_SYS) disable iff (RST)
        ARRAY_REQ.rd |-> ARRAY_REQ.waddr == TABLE_POINTER[21:1])
        else $error("read word address not from pointer");
    erase_block_fixed_a: assert property (                // [R16]
        @(posedge CLK_SYS) disable iff (RST)
        ARRAY_REQ.erase |->
            ARRAY_REQ.waddr[20:5] == TABLE_POINTER[21:6])
        else $error("erase outside selected block");
    prog_block_fixed_a: assert property (                 // [R3]
        @(posedge CLK_SYS) disable iff (RST)
        ARRAY_REQ.prog |->
            ARRAY_REQ.waddr[20:2] == TABLE_POINTER[21:3])
        else $error("block write outside selected block");
    write_ends_timer_a: assert property (                 // [R7]
        @(posedge CLK_SYS) disable iff (RST)
        $rose(WRITE_BUSY) |-> ##[1:600] !WRITE_BUSY)
        else $error("programming timer did not end operation");
    write_no_array_a: assert property (                   // [R12]
        @(posedge CLK_SYS) disable iff (RST)
        (st_r == ST_IDLE && TBL_REQ.write_op && !BULK_REQ &&
         !TBL_REQ.read_op) |=> !ARRAY_REQ.prog && TBL_DONE)
        else $error("table write touched the array");
endmodule

/* rtl/pft_pkg.sv */
// package for the program flash table access block
// assumes a single core clock and synchronous active-high reset
package pft_pkg;

    // =========================================================
    // address and data geometry
    localparam int PFT_PTR_W      = 22;
    localparam int PFT_BYTE_W     = 8;
    localparam int PFT_WORD_W     = 16;
    localparam int PFT_HOLD_N     = 8;
    localparam int PFT_HOLD_SEL_W = 3;
    localparam int PFT_ERASE_LSB  = 6;
    localparam int PFT_ERASE_N    = 64;
    localparam int PFT_ERASE_W    = 6;
    localparam int PFT_WADDR_W    = PFT_PTR_W - 1;

    // =========================================================
    // programming timer: times in ns, cycles at 250 MHz
    localparam int PFT_CLK_PS        = 4000;
    localparam int PFT_T_WRITE_NS    = 2000;
    localparam int PFT_T_ERASE_NS    = 2000;
    localparam int PFT_WRITE_CYC     =
        (PFT_T_WRITE_NS * 1000 + PFT_CLK_PS - 1) / PFT_CLK_PS;
    localparam int PFT_ERASE_CYC     =
        (PFT_T_ERASE_NS * 1000 + PFT_CLK_PS - 1) / PFT_CLK_PS;
    localparam int PFT_TMR_W         = 16;

    // pointer update applied by a table operation
    typedef enum logic [1:0] {
        PFT_PTR_KEEP,
        PFT_PTR_POSTINC,
        PFT_PTR_POSTDEC,
        PFT_PTR_PREINC
    } pft_ptr_mode_t;

    // request from the core
    typedef struct packed {
        logic                    read_op;
        logic                    write_op;
        pft_ptr_mode_t           mode;
    } pft_table_req_t;

    // request to the flash array
    typedef struct packed {
        logic                    rd;
        logic                    prog;
        logic                    erase;
        logic                    bulk;
        logic [PFT_WADDR_W-1:0]  waddr;
        logic [PFT_WORD_W-1:0]   wdata;
        logic [1:0]              wbe;
    } pft_array_req_t;

endpackage

/* rtl/pft_hold_bank.sv */
// eight byte holding registers filled by table writes
// assumes writes come from the sequencer on the same clock
`timescale 1ns/10ps
module pft_hold_bank
    import pft_pkg::*;
#(
    parameter int N = PFT_HOLD_N
) (
    input  wire logic                      CLK_SYS,
    input  wire logic                      RST,
    input  wire logic                      wr_en,
    input  wire logic [PFT_HOLD_SEL_W-1:0] wr_sel,
    input  wire logic [PFT_BYTE_W-1:0]     wr_data,
    input  wire logic                      clr,
    output logic [N*PFT_BYTE_W-1:0]        bytes_q,
    output logic [N-1:0]                   dirty_q
);
    logic [PFT_BYTE_W-1:0] hold_r   [N];
    logic [PFT_BYTE_W-1:0] hold_nxt [N];
    logic [N-1:0]          dirty_r;
    logic [N-1:0]          dirty_nxt;

    always_comb begin
        dirty_nxt = clr ? '0 : dirty_r;
        for (int i = 0; i < N; i++) begin
            hold_nxt[i] = clr ? 8'hff : hold_r[i];
            if (wr_en && wr_sel == PFT_HOLD_SEL_W'(i)) begin
                hold_nxt[i]  = wr_data;
                dirty_nxt[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            dirty_r <= '0;
            for (int i = 0; i < N; i++) hold_r[i] <= 8'hff;
        end else begin
            dirty_r <= dirty_nxt;
            for (int i = 0; i < N; i++) hold_r[i] <= hold_nxt[i];
        end
    end

    always_comb begin
        for (int i = 0; i < N; i++)
            bytes_q[i*PFT_BYTE_W +: PFT_BYTE_W] = hold_r[i];
    end
    assign dirty_q = dirty_r;
endmodule

/* rtl/pft_prog_timer.sv */
// internal programming timer that ends each write or erase pulse
// assumes start is a one-cycle pulse while the timer is idle
`timescale 1ns/10ps
module pft_prog_timer
    import pft_pkg::*;
(
    input  wire logic                 CLK_SYS,
    input  wire logic                 RST,
    input  wire logic                 start,
    input  wire logic [PFT_TMR_W-1:0] load,
    output logic                      busy,
    output logic                      done
);
    logic [PFT_TMR_W-1:0] cnt_r;
    logic [PFT_TMR_W-1:0] cnt_nxt;
    logic                 done_r;
    logic                 done_nxt;

    always_comb begin
        cnt_nxt  = cnt_r;
        done_nxt = 1'b0;
        if (start) begin
            cnt_nxt = load;
        end else if (cnt_r != '0) begin
            cnt_nxt  = cnt_r - 1'b1;
            done_nxt = (cnt_r == PFT_TMR_W'(1));
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = (cnt_r != '0);
    assign done = done_r;
endmodule

/* test/pft_flash_model.sv */
// behavioural 16-bit program flash array behind the table access block
// assumes registered array requests; a read is answered in the rd cycle
`timescale 1ns/10ps
module pft_flash_model
    import pft_pkg::*;
(
    input  wire logic             CLK_SYS,
    input  wire pft_array_req_t   ARRAY_REQ,
    output logic [PFT_WORD_W-1:0] ARRAY_RDATA
);
    // ========
    // storage and activity counters
    // limitation: only 2048 words are kept, higher addresses alias
    logic [PFT_WORD_W-1:0] mem [0:2047];
    logic [PFT_WORD_W-1:0] held_r = 16'h0000;
    logic [PFT_WORD_W-1:0] junk_r = 16'h1234;
    logic                  rd_q_r = 1'b0;
    logic [10:0]           idx;
    int                    rd_cnt = 0;
    int                    prog_cnt = 0;
    int                    erase_cnt = 0;
    int                    bulk_cnt = 0;

    assign idx = ARRAY_REQ.waddr[10:0];

    initial begin
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 16'hffff;
        end
    end

    // ========
    // read answer; the word is held one cycle after rd, then stale data scrambles so a later sample never matches
    assign ARRAY_RDATA = ARRAY_REQ.rd ? mem[idx] : (rd_q_r ? held_r : junk_r);

    // ========
    // word-wide array with byte enables
    always @(posedge CLK_SYS) begin
        rd_q_r <= ARRAY_REQ.rd;
        held_r <= mem[idx];
        junk_r <= {junk_r[14:0], ~junk_r[15]};
        if (ARRAY_REQ.rd === 1'b1) begin
            rd_cnt++;
        end
        if (ARRAY_REQ.prog === 1'b1) begin
            prog_cnt++;
            mem[idx] <= {ARRAY_REQ.wbe[1] ? ARRAY_REQ.wdata[15:8]
                                          : mem[idx][15:8],
                         ARRAY_REQ.wbe[0] ? ARRAY_REQ.wdata[7:0]
                                          : mem[idx][7:0]};
        end
        if (ARRAY_REQ.erase === 1'b1) begin
            erase_cnt++;
            mem[idx] <= 16'hffff;
        end
        if (ARRAY_REQ.bulk === 1'b1) begin
            bulk_cnt++;
        end
    end
endmodule

/* test/tb.sv */
// self-checking bench for the program flash table access block
// assumes pft_flash_model answers the array port of the block
`timescale 1ns/10ps
module tb
    import pft_pkg::*;
;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    pft_table_req_t        tbl_req = '0;
    logic [PFT_BYTE_W-1:0] latch_wdata = 8'h00;
    logic                  latch_we = 1'b0;
    logic [PFT_BYTE_W-1:0] ptr_wdata = 8'h00;
    logic [2:0]            ptr_we = 3'h0;
    logic                  write_start = 1'b0;
    logic                  erase_sel = 1'b0;
    logic                  bulk_req = 1'b0;
    logic [PFT_WORD_W-1:0] fetch_word = 16'h0000;
    logic [PFT_WORD_W-1:0] array_rdata;
    pft_array_req_t        array_req;
    logic [PFT_BYTE_W-1:0] table_latch;
    logic [PFT_PTR_W-1:0]  table_pointer;
    logic                  read_busy, write_busy, fetch_stall;
    logic                  bulk_refused, insn_nop, tbl_done;
    logic                  first_busy, first_stall;
    int                    num_errors = 0;
    int                    total_checks = 0;
    int                    cyc;

    initial begin
        forever #2 clk = ~clk;
    end

    pft_table_access DUT (
        .CLK_SYS       (clk),
        .RST           (rst),
        .TBL_REQ       (tbl_req),
        .LATCH_WDATA   (latch_wdata),
        .LATCH_WE      (latch_we),
        .PTR_WDATA     (ptr_wdata),
        .PTR_WE        (ptr_we),
        .WRITE_START   (write_start),
        .ERASE_SEL     (erase_sel),
        .BULK_REQ      (bulk_req),
        .FETCH_WORD    (fetch_word),
        .ARRAY_RDATA   (array_rdata),
        .ARRAY_REQ     (array_req),
        .TABLE_LATCH   (table_latch),
        .TABLE_POINTER (table_pointer),
        .READ_BUSY     (read_busy),
        .WRITE_BUSY    (write_busy),
        .FETCH_STALL   (fetch_stall),
        .BULK_REFUSED  (bulk_refused),
        .INSN_NOP      (insn_nop),
        .TBL_DONE      (tbl_done)
    );

    pft_flash_model FLM (
        .CLK_SYS     (clk),
        .ARRAY_REQ   (array_req),
        .ARRAY_RDATA (array_rdata)
    );

    // ========
    // shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // bounded wait; a hang leaves cyc at the bound and fails the caller
    task automatic wait_done;
        cyc = 0;
        do begin
            @(negedge clk);
            cyc++;
            if (cyc == 1) begin
                first_busy = read_busy | write_busy;
                first_stall = fetch_stall;
            end
        end while (tbl_done !== 1'b1 && cyc < 700);
    endtask

    task automatic set_ptr(input logic [23:0] p);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            ptr_wdata <= p[8*i +: 8];
            ptr_we <= 3'(1 << i);
        end
        @(posedge clk);
        ptr_we <= 3'h0;
        @(negedge clk);
    endtask

    task automatic wr_latch(input logic [7:0] d);
        @(posedge clk);
        latch_wdata <= d;
        latch_we <= 1'b1;
        @(posedge clk);
        latch_we <= 1'b0;
        @(negedge clk);
    endtask

    task automatic run_op(input logic rd, wr, input pft_ptr_mode_t m);
        @(posedge clk);
        tbl_req <= '{rd, wr, m};
        @(posedge clk);
        tbl_req <= '0;
        wait_done();
    endtask

    // a read is slipped in while busy; it must be ignored
    task automatic start_prog(input logic erase);
        @(posedge clk);
        erase_sel <= erase;
        write_start <= 1'b1;
        @(posedge clk);
        write_start <= 1'b0;
        tbl_req <= '{1'b1, 1'b0, PFT_PTR_POSTINC};
        @(posedge clk);
        tbl_req <= '0;
        wait_done();
    endtask

    // ========
    // scenarios
    task automatic t_basic;
        chk(32'(table_pointer), 32'h0);
        chk(32'({read_busy, write_busy, fetch_stall, tbl_done}), 0);
        set_ptr(24'hffa5c3);
        chk(32'(table_pointer), 32'h3fa5c3);
        wr_latch(8'h5c);
        chk(32'(table_latch), 32'h5c);
    endtask

    task automatic t_read;
        logic [21:0] sp [6] = '{22'h246, 22'h246, 22'h247, 22'h247,
                                22'h247, 22'h200000};
        pft_ptr_mode_t md [6] = '{PFT_PTR_KEEP, PFT_PTR_POSTINC,
            PFT_PTR_POSTINC, PFT_PTR_POSTDEC, PFT_PTR_PREINC, PFT_PTR_POSTDEC};
        logic [7:0] eb [6] = '{8'hef, 8'hef, 8'hbe, 8'hbe, 8'h34, 8'hff};
        logic [21:0] ep [6] = '{22'h246, 22'h247, 22'h248, 22'h246,
                                22'h248, 22'h3fffff};
        FLM.mem[11'h123] = 16'hbeef;
        FLM.mem[11'h124] = 16'h1234;
        for (int i = 0; i < 6; i++) begin
            set_ptr({2'b00, sp[i]});
            run_op(1'b1, 1'b0, md[i]);
            chk(32'(table_latch), 32'(eb[i]));
            chk(32'(table_pointer), 32'(ep[i]));
            chk(32'({first_busy, read_busy}), 32'h2);
            chk(32'(cyc), 32'h2);
        end
    endtask

    task automatic t_write;
        int p0;
        int r0;
        set_ptr(24'h000080);
        p0 = FLM.prog_cnt;
        for (int i = 0; i < 8; i++) begin
            wr_latch(8'(8'h10 + i));
            run_op(1'b0, 1'b1, i < 7 ? PFT_PTR_POSTINC : PFT_PTR_KEEP);
            chk(32'(cyc), 32'h1);
        end
        chk(32'(FLM.prog_cnt - p0), 32'h0);
        chk(32'(table_pointer), 32'h87);
        r0 = FLM.rd_cnt;
        start_prog(1'b0);
        chk(32'({first_busy, first_stall}), 32'h3);
        chk(32'(cyc >= PFT_WRITE_CYC - 2 &&
                cyc <= PFT_WRITE_CYC + 8), 1);
        chk(32'({write_busy, fetch_stall}), 32'h0);
        chk(32'(FLM.prog_cnt - p0), 32'h4);
        chk(32'(FLM.rd_cnt - r0), 32'h0);
        chk(32'(table_pointer), 32'h87);
        for (int k = 0; k < 4; k++) begin
            chk(32'(FLM.mem[11'h40 + k]),
                32'({8'(8'h11 + 2*k), 8'(8'h10 + 2*k)}));
        end
        set_ptr(24'h000083);
        run_op(1'b1, 1'b0, PFT_PTR_KEEP);
        chk(32'(table_latch), 32'h13);
    endtask

    task automatic t_erase;
        int   e0;
        logic ok;
        for (int k = 11'h5f; k <= 11'h80; k++) begin
            FLM.mem[k] = 16'h0a0a;
        end
        e0 = FLM.erase_cnt;
        set_ptr(24'h0000ed);
        start_prog(1'b1);
        chk(32'(first_stall), 32'h1);
        chk(32'(cyc >= PFT_ERASE_CYC - 2 &&
                cyc <= PFT_ERASE_CYC + 8), 1);
        chk(32'(FLM.erase_cnt - e0), 32'd32);
        ok = 1'b1;
        for (int k = 11'h60; k < 11'h80; k++) begin
            ok &= (FLM.mem[k] === 16'hffff);
        end
        chk(32'(ok), 32'h1);
        chk({FLM.mem[11'h5f], FLM.mem[11'h80]}, 32'h0a0a0a0a);
    endtask

    task automatic t_bulk;
        int e0;
        e0 = FLM.erase_cnt;
        @(posedge clk);
        bulk_req <= 1'b1;
        @(posedge clk);
        bulk_req <= 1'b0;
        @(negedge clk);
        chk(32'(bulk_refused), 32'h1);
        @(negedge clk);
        chk(32'(bulk_refused), 32'h0);
        repeat (4) @(negedge clk);
        chk(32'(FLM.bulk_cnt + FLM.erase_cnt - e0), 32'h0);
        chk(32'(FLM.mem[11'h40]), 32'h1110);
    endtask

    task automatic t_nop;
        logic [15:0] w [3] = '{16'hffff, 16'h1234, 16'h0000};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            fetch_word <= w[i];
            @(negedge clk);
            chk(32'(insn_nop), 32'(i == 0));
        end
    endtask

    // ========
    // main sequence and watchdog
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_basic();
        t_read();
        t_write();
        t_erase();
        t_bulk();
        t_nop();
        give_verdict();
    end

    // about 1150 cycles expected; generous margin before giving up
    initial begin
        repeat (4000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
endmodule
